// [rtl/vic_core.sv]
`timescale 1ns/1ps
`default_nettype none

module vic_core #(
  parameter int unsigned PORT_PINS = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // port pins, observed only
  input  wire logic [PORT_PINS-1:0]  port_pins,
  // peripheral pending flags, sources 0..15 (0 and 2 are internal)
  input  wire logic [15:0]           periph_pending,
  output logic                       timer_zero_clear,
  output logic                       timer_one_clear,
  // cpu sequencer
  input  wire logic                  instr_done,
  input  wire logic                  return_from_service_done,
  input  wire logic                  cpu_stall,
  output logic                       long_call_to_vector,
  output logic [15:0]                vector_addr,
  output logic                       call_busy
);

  // ==========================================================================
  // registers
  // ==========================================================================
  logic        global_irq_gate_q;
  logic [15:0] enable_q;
  logic [15:0] prio_q;
  logic [9:0]  extcfg_q;
  logic        ext_zero_pending_q;
  logic        ext_one_pending_q;
  logic        ext_zero_edge_q;
  logic        ext_one_edge_q;

  // ==========================================================================
  // pin synchronisers and selection
  // ==========================================================================
  logic [PORT_PINS-1:0] pin_meta_q;
  logic [PORT_PINS-1:0] pin_sync_q;
  logic                 ext_irq_zero_input;
  logic                 ext_irq_one_input;
  logic                 ext_zero_active;
  logic                 ext_one_active;
  logic                 ext_zero_act_q;
  logic                 ext_one_act_q;
  logic                 ext_zero_polarity;
  logic                 ext_one_polarity;
  logic                 ext_zero_trigger_type;
  logic                 ext_one_trigger_type;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // pins idle high, the default active-low sense: no false edge after reset
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end
    else
    begin
      pin_meta_q <= port_pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign ext_zero_polarity     = extcfg_q[vic_pkg::CFG_POL0_BIT];
  assign ext_one_polarity      = extcfg_q[vic_pkg::CFG_POL1_BIT];
  assign ext_zero_trigger_type = extcfg_q[vic_pkg::CFG_TRG0_BIT];
  assign ext_one_trigger_type  = extcfg_q[vic_pkg::CFG_TRG1_BIT];
  // read-only tap on the pin, so a crossbar peripheral keeps the pin
  assign ext_irq_zero_input = pin_sync_q[extcfg_q[vic_pkg::CFG_PIN0_LSB +: vic_pkg::PIN_SEL_W]];
  assign ext_irq_one_input  = pin_sync_q[extcfg_q[vic_pkg::CFG_PIN1_LSB +: vic_pkg::PIN_SEL_W]];
  assign ext_zero_active = ~(ext_irq_zero_input ^ ext_zero_polarity);
  assign ext_one_active  = ~(ext_irq_one_input ^ ext_one_polarity);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_zero_act_q <= 1'b0;
      ext_one_act_q  <= 1'b0;
    end
    else
    begin
      ext_zero_act_q <= ext_zero_active;
      ext_one_act_q  <= ext_one_active;
    end
  end

  // ==========================================================================
  // arbitration
  // ==========================================================================
  logic [15:0] pend_all;
  logic [15:0] req;
  logic [15:0] req_hi;
  logic [15:0] req_lo;
  logic        any_hi;
  logic        any_lo;
  logic [3:0]  win_hi;
  logic [3:0]  win_lo;
  logic        run_lo_q;
  logic        run_hi_q;
  logic        allow_hi;
  logic        allow_lo;
  logic        grant;
  logic [3:0]  grant_src;
  logic        grant_hi;

  always_comb
  begin
    pend_all = periph_pending;
    pend_all[vic_pkg::SRC_EXT0] = ext_zero_pending_q;
    pend_all[vic_pkg::SRC_EXT1] = ext_one_pending_q;
  end

  assign req    = pend_all & enable_q & {16{global_irq_gate_q}};
  assign req_hi = req & prio_q;
  assign req_lo = req & ~prio_q;
  assign any_hi = |req_hi;
  assign any_lo = |req_lo;

  // lowest index wins inside a level
  always_comb
  begin
    win_hi = '0;
    win_lo = '0;
    for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (req_hi[i]) win_hi = 4'(i);
      if (req_lo[i]) win_lo = 4'(i);
    end
  end

  vic_pkg::vic_state_t state_q;
  logic [2:0]          call_cnt_q;
  logic [3:0]          call_src_q;

  // high only blocked by a running high routine; low by any running routine
  assign allow_hi  = ~run_hi_q;
  assign allow_lo  = ~run_hi_q & ~run_lo_q;
  assign grant     = (state_q == vic_pkg::VIC_IDLE) && !cpu_stall && instr_done &&
                     ((any_hi && allow_hi) || (any_lo && allow_lo));
  assign grant_hi  = any_hi && allow_hi;
  assign grant_src = grant_hi ? win_hi : win_lo;

  // ==========================================================================
  // vectoring sequence
  // ==========================================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q    <= vic_pkg::VIC_IDLE;
      call_cnt_q <= '0;
      call_src_q <= '0;
    end
    else
    begin
      case (state_q)
        vic_pkg::VIC_IDLE:
        begin
          // no call in the return cycle; the next boundary is one instruction on
          if (grant && !return_from_service_done)
          begin
            call_src_q <= grant_src;
            call_cnt_q <= vic_pkg::CALL_CYCLES - 3'h1;
            state_q    <= vic_pkg::VIC_CALL;
          end
        end
        vic_pkg::VIC_CALL:
        begin
          // a stall freezes the call, so latency grows by the stall
          if (!cpu_stall)
          begin
            if (call_cnt_q == 3'h1)
              state_q <= vic_pkg::VIC_IDLE;
            call_cnt_q <= call_cnt_q - 3'h1;
          end
        end
        default:
          state_q <= vic_pkg::VIC_IDLE;
      endcase
    end
  end

  // nesting tracker: at most one low and one high routine live
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_lo_q <= 1'b0;
      run_hi_q <= 1'b0;
    end
    else if (state_q == vic_pkg::VIC_IDLE && return_from_service_done)
    begin
      if (run_hi_q)
        run_hi_q <= 1'b0;
      else
        run_lo_q <= 1'b0;
    end
    else if (state_q == vic_pkg::VIC_IDLE && grant)
    begin
      if (grant_hi)
        run_hi_q <= 1'b1;
      else
        run_lo_q <= 1'b1;
    end
  end

  logic vec_fire;
  assign vec_fire = (state_q == vic_pkg::VIC_IDLE) && grant && !return_from_service_done;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      long_call_to_vector <= 1'b0;
      vector_addr         <= vic_pkg::VEC_RESET;
      timer_zero_clear    <= 1'b0;
      timer_one_clear     <= 1'b0;
    end
    else
    begin
      long_call_to_vector <= state_q == vic_pkg::VIC_CALL && !cpu_stall &&
                             call_cnt_q == 3'h1;
      if (vec_fire)
        vector_addr <= vic_pkg::VEC_BASE + ({12'h000, grant_src} << vic_pkg::VEC_SHIFT);
      timer_zero_clear <= vec_fire && grant_src == vic_pkg::SRC_TMR0;
      timer_one_clear  <= vec_fire && grant_src == vic_pkg::SRC_TMR1;
    end
  end

  assign call_busy = state_q != vic_pkg::VIC_IDLE;

  // ==========================================================================
  // axi4-lite slave
  // ==========================================================================
  logic       aw_hold_q;
  logic       w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_go;
  logic       wr_timer_control_reg;
  logic       wr_hit;

  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  assign wr_go   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign wr_timer_control_reg = wr_go && aw_addr_q == vic_pkg::ADDR_TIMER_CONTROL_REG && w_strb_q[0];
  assign wr_hit  = aw_addr_q == vic_pkg::ADDR_CTRL || aw_addr_q == vic_pkg::ADDR_ENABLE ||
                   aw_addr_q == vic_pkg::ADDR_PRIO || aw_addr_q == vic_pkg::ADDR_EXTCFG ||
                   aw_addr_q == vic_pkg::ADDR_TIMER_CONTROL_REG || aw_addr_q == vic_pkg::ADDR_STATUS;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      aw_addr_q    <= '0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= vic_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // control registers, byte-lane writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      global_irq_gate_q <= 1'b0;
      enable_q          <= '0;
      prio_q            <= '0;
      extcfg_q          <= '0;
    end
    else if (wr_go)
    begin
      if (aw_addr_q == vic_pkg::ADDR_CTRL && w_strb_q[0])
        global_irq_gate_q <= w_data_q[0];
      for (int b = 0; b < 2; b++)
      begin
        if (w_strb_q[b] && aw_addr_q == vic_pkg::ADDR_ENABLE)
          enable_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
        if (w_strb_q[b] && aw_addr_q == vic_pkg::ADDR_PRIO)
          prio_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
      end
      if (aw_addr_q == vic_pkg::ADDR_EXTCFG && w_strb_q[0])
        extcfg_q[7:0] <= w_data_q[7:0];
      if (aw_addr_q == vic_pkg::ADDR_EXTCFG && w_strb_q[1])
        extcfg_q[9:8] <= w_data_q[9:8];
    end
  end

  // external pending flags; a hardware set beats a software clear
  logic ext_zero_rise;
  logic ext_one_rise;
  logic clr_ext0;
  logic clr_ext1;
  assign ext_zero_rise = ext_zero_active & ~ext_zero_act_q;
  assign ext_one_rise  = ext_one_active & ~ext_one_act_q;
  assign clr_ext0 = vec_fire && grant_src == vic_pkg::SRC_EXT0;
  assign clr_ext1 = vec_fire && grant_src == vic_pkg::SRC_EXT1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_zero_edge_q <= 1'b0;
      ext_one_edge_q  <= 1'b0;
    end
    else
    begin
      if (ext_zero_rise)
        ext_zero_edge_q <= 1'b1;
      else if (clr_ext0 || (wr_timer_control_reg && !w_data_q[vic_pkg::TIMER_CONTROL_REG_EXT0_BIT]))
        ext_zero_edge_q <= 1'b0;
      else if (wr_timer_control_reg)
        ext_zero_edge_q <= 1'b1;
      if (ext_one_rise)
        ext_one_edge_q <= 1'b1;
      else if (clr_ext1 || (wr_timer_control_reg && !w_data_q[vic_pkg::TIMER_CONTROL_REG_EXT1_BIT]))
        ext_one_edge_q <= 1'b0;
      else if (wr_timer_control_reg)
        ext_one_edge_q <= 1'b1;
    end
  end

  always_comb
  begin
    ext_zero_pending_q = ext_zero_trigger_type ? ext_zero_edge_q : ext_zero_act_q;
    ext_one_pending_q  = ext_one_trigger_type ? ext_one_edge_q : ext_one_act_q;
  end

  // read channel
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [7:0]  timer_control_reg;

  always_comb
  begin
    timer_control_reg = '0;
    timer_control_reg[vic_pkg::TIMER_CONTROL_REG_EXT0_BIT] = ext_zero_pending_q;
    timer_control_reg[vic_pkg::TIMER_CONTROL_REG_EXT1_BIT] = ext_one_pending_q;
    timer_control_reg[vic_pkg::TIMER_CONTROL_REG_TMR0_BIT] = periph_pending[vic_pkg::SRC_TMR0];
    timer_control_reg[vic_pkg::TIMER_CONTROL_REG_TMR1_BIT] = periph_pending[vic_pkg::SRC_TMR1];
    rd_hit  = 1'b1;
    rd_word = '0;
    case (s_axi_araddr)
      vic_pkg::ADDR_CTRL:   rd_word = {31'h0, global_irq_gate_q};
      vic_pkg::ADDR_ENABLE: rd_word = {16'h0, enable_q};
      vic_pkg::ADDR_PRIO:   rd_word = {16'h0, prio_q};
      vic_pkg::ADDR_EXTCFG: rd_word = {22'h0, extcfg_q};
      vic_pkg::ADDR_TIMER_CONTROL_REG:   rd_word = {24'h0, timer_control_reg};
      vic_pkg::ADDR_STATUS: rd_word = {4'h0, state_q, call_src_q,
                                       2'h0, run_hi_q, run_lo_q, req};
      default:              rd_hit  = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= vic_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

`default_nettype wire

// [rtl/vic_pkg.sv]
package vic_pkg;

  // ==========================================================================
  // source numbering, fixed tie-break order
  // ==========================================================================
  localparam int unsigned NUM_SRC       = 16;
  localparam int unsigned SRC_W         = 4;
  localparam logic [3:0]  SRC_EXT0      = 4'h0;
  localparam logic [3:0]  SRC_TMR0      = 4'h1;
  localparam logic [3:0]  SRC_EXT1      = 4'h2;
  localparam logic [3:0]  SRC_TMR1      = 4'h3;

  // ==========================================================================
  // vector addresses
  // ==========================================================================
  localparam logic [15:0] VEC_RESET     = 16'h0000;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam int unsigned VEC_SHIFT     = 3;

  // ==========================================================================
  // timer control register bit positions
  // ==========================================================================
  localparam int unsigned TIMER_CONTROL_REG_EXT0_BIT = 1;
  localparam int unsigned TIMER_CONTROL_REG_EXT1_BIT = 3;
  localparam int unsigned TIMER_CONTROL_REG_TMR0_BIT = 5;
  localparam int unsigned TIMER_CONTROL_REG_TMR1_BIT = 7;

  // ==========================================================================
  // register map (axi4-lite byte offsets)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_ENABLE    = 8'h04;
  localparam logic [7:0] ADDR_PRIO      = 8'h08;
  localparam logic [7:0] ADDR_EXTCFG    = 8'h0c;
  localparam logic [7:0] ADDR_TIMER_CONTROL_REG      = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // extcfg fields
  localparam int unsigned CFG_PIN0_LSB  = 0;
  localparam int unsigned CFG_POL0_BIT  = 3;
  localparam int unsigned CFG_PIN1_LSB  = 4;
  localparam int unsigned CFG_POL1_BIT  = 7;
  localparam int unsigned CFG_TRG0_BIT  = 8;
  localparam int unsigned CFG_TRG1_BIT  = 9;
  localparam int unsigned PIN_SEL_W     = 3;

  // ==========================================================================
  // timing in system clock cycles
  // ==========================================================================
  localparam logic [2:0] CALL_CYCLES    = 3'h4;

  typedef enum logic [3:0] {
    VIC_IDLE  = 4'b0001,
    VIC_CALL  = 4'b0010,
    VIC_RETW  = 4'b0100,
    VIC_HOLD  = 4'b1000
  } vic_state_t;

endpackage

// [sim/vectored_interrupt_controller_tb.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  num_checks++; \
  if ((got) !== (exp)) \
  begin \
    error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
  end

// ==========================================================================
// bench
// ==========================================================================
module vectored_interrupt_controller_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, timer_zero_clear, timer_one_clear, instr_done, return_from_service_done;
  logic        cpu_stall, long_call_to_vector, call_busy, stall_req;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, port_pins;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, pace;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] periph_pending, vector_addr, clr_m;
  logic [15:0] vec_q[$];
  int          error_cnt, num_checks, cyc;

  vic_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_pins, .periph_pending, .timer_zero_clear, .timer_one_clear,
    .instr_done, .return_from_service_done, .cpu_stall, .long_call_to_vector, .vector_addr, .call_busy);
  vic_cpu_model u_cpu (.aclk, .aresetn, .pace, .stall_req, .long_call_to_vector, .call_busy,
    .instr_done, .return_from_service_done, .cpu_stall);

  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  // calls seen mid-cycle; the routine clears its own flag next edge
  always @(negedge aclk)
    if (long_call_to_vector === 1'b1)
    begin
      vec_q.push_back(vector_addr);
      clr_m = 16'h1 << ((vector_addr - 16'h3) >> 3);
    end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      summarize();
    end
    if (clr_m != 16'h0)
      periph_pending <= periph_pending & ~clr_m;
    clr_m = 16'h0;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // each channel moves at the edge where valid and ready are both sampled high
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
    end
    while ((s_axi_bvalid && s_axi_bready) !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && !s_axi_rready) s_axi_rready <= 1'b1;
    end
    while ((s_axi_rvalid && s_axi_rready) !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic expect_vec(input logic [15:0] v);
    logic [15:0] got;
    got = 16'hxxxx;
    repeat (300)
      if (vec_q.size() == 0) @(posedge aclk);
    if (vec_q.size() != 0) got = vec_q.pop_front();
    `CHK("vector", v, got)
    @(posedge aclk);
  endtask

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {aresetn, stall_req, pace, periph_pending, clr_m} = '0;
    s_axi_wstrb = 4'hf;
    port_pins = 8'hff;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("reset vector", 16'h0000, vector_addr)
    rd(vic_pkg::ADDR_PRIO);
    `CHK("prio reset", 32'h0, d)
    rd(vic_pkg::ADDR_CTRL);
    `CHK("gate reset", 32'h0, d)
    rd(8'h18);
    `CHK("unmapped resp", vic_pkg::RESP_SLVERR, r)
    wr(8'h18, 32'h1);
    `CHK("unmapped wr resp", vic_pkg::RESP_SLVERR, r)
    wr(vic_pkg::ADDR_ENABLE, 32'hffff);
    `CHK("write resp", vic_pkg::RESP_OKAY, r)
    periph_pending <= 16'h0002;
    repeat (30) @(posedge aclk);
    `CHK("masked calls", 0, vec_q.size())
    wr(vic_pkg::ADDR_CTRL, 32'h1);
    expect_vec(16'h000b);
    $display("test gate done");
    repeat (40) @(posedge aclk);
    periph_pending <= 16'hfffa;
    for (int i = 1; i < 16; i++)
      if (i != 2) expect_vec(16'h0003 + 16'(8 * i));
    $display("test order done");
    repeat (40) @(posedge aclk);
    pace <= 4'h3;
    wr(vic_pkg::ADDR_CTRL, 32'h0);
    wr(vic_pkg::ADDR_PRIO, 32'h1000);
    periph_pending <= 16'h1010;
    wr(vic_pkg::ADDR_CTRL, 32'h1);
    expect_vec(16'h0063);
    expect_vec(16'h0023);
    repeat (80) @(posedge aclk);
    periph_pending <= 16'h0010;
    expect_vec(16'h0023);
    periph_pending <= 16'h1000;
    expect_vec(16'h0063);
    rd(vic_pkg::ADDR_STATUS);
    `CHK("both running", 2'h3, d[17:16])
    $display("test priority done");
    repeat (80) @(posedge aclk);
    stall_req <= 1'b1;
    periph_pending <= 16'h0020;
    repeat (20) @(posedge aclk);
    `CHK("stalled calls", 0, vec_q.size())
    stall_req <= 1'b0;
    expect_vec(16'h002b);
    $display("test stall done");
    repeat (80) @(posedge aclk);
    pace <= 4'h0;
    port_pins <= 8'hfb;
    wr(vic_pkg::ADDR_EXTCFG, 32'h15a);
    repeat (5) @(posedge aclk);
    port_pins <= 8'hff;
    expect_vec(16'h0003);
    rd(vic_pkg::ADDR_TIMER_CONTROL_REG);
    `CHK("edge flag", 1'b0, d[1])
    wr(vic_pkg::ADDR_CTRL, 32'h0);
    port_pins <= 8'hdf;
    repeat (5) @(posedge aclk);
    rd(vic_pkg::ADDR_TIMER_CONTROL_REG);
    `CHK("level flag on", 1'b1, d[3])
    port_pins <= 8'hff;
    repeat (5) @(posedge aclk);
    rd(vic_pkg::ADDR_TIMER_CONTROL_REG);
    `CHK("level flag off", 1'b0, d[3])
    $display("test external done");
    summarize();
  end
endmodule

`default_nettype wire

// [sim/vic_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// cpu sequencer: instruction pacing, routine bodies, returns
// ==========================================================================
module vic_cpu_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] pace,
  input  wire logic       stall_req,
  input  wire logic       long_call_to_vector,
  input  wire logic       call_busy,
  output logic            instr_done,
  output logic            return_from_service_done,
  output logic            cpu_stall
);
  logic [3:0] gap_q;
  logic [1:0] depth_q;
  logic [1:0] body_q;

  // stalled cpu completes nothing, so the bench sees the hold-off
  assign cpu_stall = stall_req;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {gap_q, depth_q, body_q, instr_done, return_from_service_done} <= '0;
    end
    else
    begin
      instr_done <= 1'b0;
      return_from_service_done <= 1'b0;
      if (long_call_to_vector)
      begin
        depth_q <= depth_q + 2'h1;
        body_q <= 2'h3;
      end
      else if (!stall_req && !call_busy)
      begin
        gap_q <= (gap_q == pace) ? 4'h0 : gap_q + 4'h1;
        // return only after the body, never back to back with a call
        if (gap_q == pace && depth_q != 2'h0 && body_q == 2'h0)
        begin
          return_from_service_done <= 1'b1;
          depth_q <= depth_q - 2'h1;
        end
        else if (gap_q == pace)
        begin
          instr_done <= 1'b1;
          body_q <= (body_q == 2'h0) ? 2'h0 : body_q - 2'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [sim/vic_props.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// call sequence and bus response checks
// ==========================================================================
module vic_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        instr_done,
  input wire logic        cpu_stall,
  input wire logic        timer_zero_clear,
  input wire logic        timer_one_clear,
  input wire logic        long_call_to_vector,
  input wire logic [15:0] vector_addr,
  input wire logic        call_busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence grant_s;
    $rose(call_busy);
  endsequence

  call_lat_a: assert property (grant_s ##0 !cpu_stall ##1 !cpu_stall [*2]
    |=> long_call_to_vector) else $error("call not done four cycles after grant");
  call_end_a: assert property (long_call_to_vector |=> !long_call_to_vector && !call_busy)
    else $error("call pulse or busy too long");
  grant_edge_a: assert property (grant_s |-> $past(instr_done) && !$past(cpu_stall))
    else $error("grant off an instruction boundary or in a stall");
  busy_len_a: assert property (grant_s |-> call_busy [*3] ##1
    (long_call_to_vector || call_busy)) else $error("call sequence shorter than four cycles");
  vec_table_a: assert property (grant_s |-> vector_addr[2:0] == 3'h3 && vector_addr <= 16'h007b)
    else $error("vector outside the table");
  vec_hold_a: assert property (call_busy && $past(call_busy) |-> $stable(vector_addr))
    else $error("vector changed during call");
  tmr0_clr_a: assert property (timer_zero_clear |-> $rose(call_busy) && vector_addr == 16'h000b)
    else $error("timer zero clear without its vector");
  tmr1_clr_a: assert property (timer_one_clear |-> $rose(call_busy) && vector_addr == 16'h001b)
    else $error("timer one clear without its vector");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  cover property ($rose(call_busy) && vector_addr == 16'h0003);
  cover property (timer_one_clear);
  cover property ($fell(cpu_stall) ##[1:10] $rose(call_busy));
endmodule

bind vic_core vic_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .instr_done, .cpu_stall, .timer_zero_clear,
  .timer_one_clear, .long_call_to_vector, .vector_addr, .call_busy);

`default_nettype wire
